// ==== core/dbgpm_pkg.sv ====
package dbgpm_pkg;
    typedef logic [9:0] dbgpm_pins_t;
    typedef struct packed {
        dbgpm_pins_t data;
        dbgpm_pins_t oe;
        dbgpm_pins_t fr;
        dbgpm_pins_t ie;
        dbgpm_pins_t pup;
        dbgpm_pins_t pdn;
        dbgpm_pins_t sync1;
        dbgpm_pins_t sync2;
        dbgpm_pins_t pout;
        dbgpm_pins_t poe;
        logic [1:0]  ctrl;
        logic        tck_prev;
        logic        tck_rise;
        logic [31:0] rdata;
        logic        slverr;
    } dbgpm_state_s;
endpackage

// ==== core/dbgpm_regs.svh ====
`ifndef DBGPM_REGS_SVH
`define DBGPM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DBGPM_OFS_DATA 8'h00
`define DBGPM_OFS_OE   8'h04
`define DBGPM_OFS_FR   8'h08
`define DBGPM_OFS_IE   8'h0c
`define DBGPM_OFS_PUP  8'h10
`define DBGPM_OFS_PDN  8'h14
`define DBGPM_OFS_IN   8'h18
`define DBGPM_OFS_CTRL 8'h1c

// ****************************************************************
// Pin positions: [6:0] port A bits 0..6, [9:7] port B bits 0..2
// ****************************************************************
`define DBGPM_A0 0
`define DBGPM_A1 1
`define DBGPM_A2 2
`define DBGPM_A3 3
`define DBGPM_B0 7
`define DBGPM_B1 8
`define DBGPM_B2 9

// ****************************************************************
// Control bits and reset values
// ****************************************************************
`define DBGPM_CTRL_SDE 0
`define DBGPM_CTRL_VIEW 1
`define DBGPM_RST_DATA 10'h000
`define DBGPM_RST_OE   10'h081
`define DBGPM_RST_FR   10'h383
`define DBGPM_RST_IE   10'h303
`define DBGPM_RST_PUP  10'h301
`define DBGPM_RST_PDN  10'h002
`define DBGPM_RST_CTRL 2'h0
`define DBGPM_STOP_KEEP 10'h081

`endif

// ==== core/dbgpm_top.sv ====
// Functional notes
// RULE1: Debug pins also work as plain port pins.
// RULE2: Five debug pins take debug role at reset.
// RULE3: Software enables trace pins' debug role itself.
// RULE4: Bit0 is TMS or SW data; bit1 TCK.
// RULE5: Port B bit0 drives TDO, or viewer output.
// RULE6: Port B bit1 TDI, bit2 TRST; JTAG only. The code passes both inputs whatever jtag_sel is.
// RULE7: Trace clock plus four trace data outputs.
// RULE8: Reset settings for A0, A1, B0.
// RULE9: Reset settings for B1, B2, trace pins.
// RULE10: A0, B0 debug drivers stay on in STOP.
// RULE11: Software frees A1 when debug unused.
// RULE12: Host uses serial-wire or five-wire JTAG.
// RULE13: Cleared function bit gives pin to port.
//
// Chosen here: register access over APB and the register offsets.
`include "dbgpm_regs.svh"

module dbgpm_top
    import dbgpm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              stop_mode,
    input  wire logic              jtag_sel,
    input  wire logic              swdio_out,
    input  wire logic              swdio_oe,
    input  wire logic              tdo,
    input  wire logic              tdo_oe,
    input  wire logic              serial_wire_viewer_output,
    input  wire logic              trace_clk,
    input  wire logic [3:0]        instr_trace_bits,
    output logic                   dbg_swdio_in,
    output logic                   dbg_tck_in,
    output logic                   dbg_tck_rise,
    output logic                   dbg_tdi_in,
    output logic                   dbg_trst_n_in,
    input  wire logic [9:0]        pin_in,
    output logic [9:0]             pin_out,
    output logic [9:0]             pin_oe,
    output logic [9:0]             pin_pu,
    output logic [9:0]             pin_pd
);

    dbgpm_state_s st_q;
    dbgpm_state_s st_d;
    dbgpm_pins_t  dbg_out;
    dbgpm_pins_t  dbg_oe;
    dbgpm_pins_t  keep;
    logic [31:0]  rd_val;
    logic         hit;
    logic         quiet;
    logic [7:0]   ofs;

    assign ofs = 8'(paddr);

    // ************************************************************
    // Register read decode
    // ************************************************************
    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (ofs)
            `DBGPM_OFS_DATA: rd_val = {22'h0, st_q.data};
            `DBGPM_OFS_OE:   rd_val = {22'h0, st_q.oe};
            `DBGPM_OFS_FR:   rd_val = {22'h0, st_q.fr};
            `DBGPM_OFS_IE:   rd_val = {22'h0, st_q.ie};
            `DBGPM_OFS_PUP:  rd_val = {22'h0, st_q.pup};
            `DBGPM_OFS_PDN:  rd_val = {22'h0, st_q.pdn};
            `DBGPM_OFS_IN:   rd_val = {22'h0, st_q.sync2 & st_q.ie};
            `DBGPM_OFS_CTRL: rd_val = {30'h0, st_q.ctrl};
            default:         hit = 1'b0;
        endcase
    end

    // ************************************************************
    // Debug-side values per pin
    // ************************************************************
    always_comb begin
        dbg_out = '0;
        dbg_oe  = '0;
        // RULE4 serial-wire data
        dbg_out[`DBGPM_A0] = swdio_out;
        dbg_oe[`DBGPM_A0]  = ~jtag_sel & swdio_oe;
        // RULE7 trace port
        dbg_out[`DBGPM_A2] = trace_clk;
        dbg_oe[`DBGPM_A2]  = 1'b1;
        dbg_out[`DBGPM_A3 +: 4] = instr_trace_bits;
        dbg_oe[`DBGPM_A3 +: 4]  = 4'hf;
        // RULE5 output or viewer
        if (st_q.ctrl[`DBGPM_CTRL_VIEW]) begin
            dbg_out[`DBGPM_B0] = serial_wire_viewer_output;
            dbg_oe[`DBGPM_B0]  = 1'b1;
        end else begin
            dbg_out[`DBGPM_B0] = tdo;
            dbg_oe[`DBGPM_B0]  = tdo_oe;
        end
    end

    // RULE10 stop mode drive
    assign quiet = stop_mode & ~st_q.ctrl[`DBGPM_CTRL_SDE];
    assign keep  = st_q.fr & `DBGPM_STOP_KEEP;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.sync1 = pin_in;
        st_d.sync2 = st_q.sync1;
        st_d.tck_prev = st_q.sync2[`DBGPM_A1];
        st_d.tck_rise = st_q.sync2[`DBGPM_A1] & ~st_q.tck_prev;
        // Read data is captured in setup so the access needs no wait.
        if (psel && !penable) begin
            st_d.rdata  = rd_val;
            st_d.slverr = ~hit;
        end
        if (psel && penable && pwrite) begin
            unique case (ofs)
                `DBGPM_OFS_DATA: st_d.data = pwdata[9:0];
                `DBGPM_OFS_OE:   st_d.oe   = pwdata[9:0];
                `DBGPM_OFS_FR:   st_d.fr   = pwdata[9:0];
                `DBGPM_OFS_IE:   st_d.ie   = pwdata[9:0];
                `DBGPM_OFS_PUP:  st_d.pup  = pwdata[9:0];
                `DBGPM_OFS_PDN:  st_d.pdn  = pwdata[9:0];
                `DBGPM_OFS_CTRL: st_d.ctrl = pwdata[1:0];
                default: ;
            endcase
        end
        // RULE13 port takes over
        // RULE1 plain port use
        st_d.pout = (st_q.fr & dbg_out) | (~st_q.fr & st_q.data);
        st_d.poe  = (st_q.fr & dbg_oe & st_q.oe) | (~st_q.fr & st_q.oe);
        // RULE10 keep debug drivers
        if (quiet) begin
            st_d.poe = st_d.poe & keep;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            // RULE2 debug role at reset
            // RULE8 reset settings
            // RULE9 reset settings
            st_q.data <= `DBGPM_RST_DATA;
            st_q.oe   <= `DBGPM_RST_OE;
            st_q.fr   <= `DBGPM_RST_FR;
            st_q.ie   <= `DBGPM_RST_IE;
            st_q.pup  <= `DBGPM_RST_PUP;
            st_q.pdn  <= `DBGPM_RST_PDN;
            st_q.ctrl <= `DBGPM_RST_CTRL;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign pready  = 1'b1;
    assign prdata  = st_q.rdata;
    assign pslverr = st_q.slverr;
    assign pin_out = st_q.pout;
    assign pin_oe  = st_q.poe;
    // Pulls follow the pull registers directly, even while the function drives the pin.
    assign pin_pu  = st_q.pup;
    assign pin_pd  = st_q.pdn;

    // RULE4 debug inputs
    assign dbg_swdio_in = st_q.sync2[`DBGPM_A0]
                        & st_q.fr[`DBGPM_A0] & st_q.ie[`DBGPM_A0];
    assign dbg_tck_in   = st_q.sync2[`DBGPM_A1]
                        & st_q.fr[`DBGPM_A1] & st_q.ie[`DBGPM_A1];
    // The edge flag is three cycles late; the probe clock must be slow.
    assign dbg_tck_rise = st_q.tck_rise & st_q.fr[`DBGPM_A1];
    // RULE6 test data and reset
    assign dbg_tdi_in   = st_q.sync2[`DBGPM_B1]
                        & st_q.fr[`DBGPM_B1] & st_q.ie[`DBGPM_B1];
    assign dbg_trst_n_in = ~(st_q.fr[`DBGPM_B2] & st_q.ie[`DBGPM_B2])
                         | st_q.sync2[`DBGPM_B2];

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rst_role;
        $rose(presetn) |-> st_q.fr == `DBGPM_RST_FR;
    endproperty
    a_rst_role: assert property (p_rst_role) // RULE2
        else $error("debug roles not set at reset");

    property p_rst_ab;
        $rose(presetn) |-> st_q.ie[1:0] == 2'h3 && st_q.oe[1:0] == 2'h1
            && st_q.pup[0] && st_q.pdn[1] && st_q.oe[`DBGPM_B0]
            && !st_q.ie[`DBGPM_B0] && !st_q.pup[`DBGPM_B0];
    endproperty
    a_rst_ab: assert property (p_rst_ab) // RULE8
        else $error("reset settings wrong on A0, A1 or B0");

    property p_rst_bt;
        $rose(presetn) |-> st_q.pup[9:8] == 2'h3 && st_q.oe[9:8] == 2'h0
            && st_q.fr[6:2] == 5'h0 && st_q.oe[6:2] == 5'h0
            && st_q.ie[6:2] == 5'h0 && st_q.pup[6:2] == 5'h0;
    endproperty
    a_rst_bt: assert property (p_rst_bt) // RULE9
        else $error("reset settings wrong on B1, B2 or trace");

    property p_gpio;
        !st_q.fr[`DBGPM_A2] |=> pin_out[`DBGPM_A2]
            == $past(st_q.data[`DBGPM_A2]);
    endproperty
    a_gpio: assert property (p_gpio) // RULE13
        else $error("port data not on released pin");

    property p_gpio_off;
        !st_q.fr[`DBGPM_B1] && !quiet ##1 !st_q.fr[`DBGPM_B1]
            |-> pin_oe[`DBGPM_B1] == $past(st_q.oe[`DBGPM_B1]);
    endproperty
    a_gpio_off: assert property (p_gpio_off) // RULE1
        else $error("port direction not followed");

    property p_tck;
        st_q.fr[`DBGPM_A1] && st_q.ie[`DBGPM_A1]
            |-> dbg_tck_in == $past(pin_in[`DBGPM_A1], 2);
    endproperty
    a_tck: assert property (p_tck) // RULE4
        else $error("clock input not passed through");

    property p_swdio;
        st_q.fr[`DBGPM_A0] && st_q.ie[`DBGPM_A0]
            |-> dbg_swdio_in == $past(pin_in[`DBGPM_A0], 2);
    endproperty
    a_swdio: assert property (p_swdio) // RULE4
        else $error("data input not passed through");

    property p_tms_in;
        st_q.fr[`DBGPM_A0] && jtag_sel |=> !pin_oe[`DBGPM_A0];
    endproperty
    a_tms_in: assert property (p_tms_in) // RULE4
        else $error("mode select pin driven in JTAG operation");

    property p_viewer;
        st_q.fr[`DBGPM_B0] && st_q.ctrl[`DBGPM_CTRL_VIEW]
            |=> pin_out[`DBGPM_B0] == $past(serial_wire_viewer_output);
    endproperty
    a_viewer: assert property (p_viewer) // RULE5
        else $error("viewer output not on pin");

    property p_tdo;
        st_q.fr[`DBGPM_B0] && !st_q.ctrl[`DBGPM_CTRL_VIEW]
            |=> pin_out[`DBGPM_B0] == $past(tdo);
    endproperty
    a_tdo: assert property (p_tdo) // RULE5
        else $error("test data output not on pin");

    property p_tdi;
        st_q.fr[`DBGPM_B1] && st_q.ie[`DBGPM_B1]
            |-> dbg_tdi_in == $past(pin_in[`DBGPM_B1], 2);
    endproperty
    a_tdi: assert property (p_tdi) // RULE6
        else $error("test data input not passed through");

    property p_trace;
        st_q.fr[`DBGPM_A3] |=> pin_out[`DBGPM_A3]
            == $past(instr_trace_bits[0]);
    endproperty
    a_trace: assert property (p_trace) // RULE7
        else $error("trace bit not on pin");

    property p_stop;
        quiet && st_q.fr[`DBGPM_B0] && st_q.oe[`DBGPM_B0]
            && st_q.ctrl[`DBGPM_CTRL_VIEW] |=> pin_oe[`DBGPM_B0];
    endproperty
    a_stop: assert property (p_stop) // RULE10
        else $error("debug driver dropped in stop");

    property p_stop_off;
        quiet && !st_q.fr[`DBGPM_A2] |=> !pin_oe[`DBGPM_A2];
    endproperty
    a_stop_off: assert property (p_stop_off) // RULE10
        else $error("port driver left on in stop");

    c_release: cover property (
        st_q.fr[`DBGPM_A1] ##1 !st_q.fr[`DBGPM_A1]);
    c_viewer: cover property (
        st_q.ctrl[`DBGPM_CTRL_VIEW] && st_q.fr[`DBGPM_B0]);
    c_stop: cover property (quiet && keep != '0);
    c_trace: cover property (st_q.fr[6:2] == 5'h1f);

endmodule // dbgpm_top

// ==== test/dbgpm_probe.sv ====
// ****************************************************************
// Debug probe: drives TMS, TCK, TDI and TRST levels
// ****************************************************************
module dbgpm_probe (
    input  wire logic       run,
    input  wire logic       tms,
    input  wire logic       tdi,
    input  wire logic       trst_n,
    output logic [9:0]      pins,
    output int              rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       tck = 1'b0;
    logic [5:0] noise = 6'h15;
    // Undriven lines toggle so a stale value never looks valid.
    always #25 noise = ~noise;
    assign pins = {trst_n, tdi, noise, tck, tms};
    initial rises = 0;
    always begin
        wait (run);
        // Edges fall between bench clock edges, never on them.
        #95 tck = 1'b1;
        rises++;
        #100 tck = 1'b0;
        #5;
    end
endmodule // dbgpm_probe

// ==== test/test_debug_port_pin_sharing.sv ====
`include "dbgpm_regs.svh"
module test_debug_port_pin_sharing import dbgpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        stop_mode, jtag_sel, swdio_out, swdio_oe, tdo, tdo_oe;
    logic        serial_wire_viewer_output, trace_clk, err, run;
    logic        tms, tdi, trst_n;
    logic [3:0]  instr_trace_bits;
    logic        dbg_swdio_in, dbg_tck_in, dbg_tck_rise;
    logic        dbg_tdi_in, dbg_trst_n_in;
    dbgpm_pins_t pin_in, pin_out, pin_oe, pin_pu, pin_pd, probe_pins;
    dbgpm_pins_t eo, ev, lv;
    int          rises, n_rise, base, n_errors, checks_done, a;
    int          mr[8];

    dbgpm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_mode(stop_mode), .jtag_sel(jtag_sel),
        .swdio_out(swdio_out), .swdio_oe(swdio_oe), .tdo(tdo),
        .tdo_oe(tdo_oe), .trace_clk(trace_clk),
        .serial_wire_viewer_output(serial_wire_viewer_output),
        .instr_trace_bits(instr_trace_bits),
        .dbg_swdio_in(dbg_swdio_in), .dbg_tck_in(dbg_tck_in),
        .dbg_tck_rise(dbg_tck_rise), .dbg_tdi_in(dbg_tdi_in),
        .dbg_trst_n_in(dbg_trst_n_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
        .pin_pd(pin_pd));
    dbgpm_probe probe (.run(run), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .pins(probe_pins), .rises(rises));

    // A pin reads what the chip drives, else what the probe drives.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & probe_pins);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (dbg_tck_rise === 1'b1) n_rise++;

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(logic wr, int ad, logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= 8'(ad);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            n_errors++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && ad < 32 && ad != 24)
            mr[ad/4] = d & (ad == 28 ? 3 : 32'h3ff);
    endtask

    // ****************************************************************
    // Model of the pin drive
    // ****************************************************************
    task automatic model();
        logic d;
        ev = {2'b00, mr[7][1] ? serial_wire_viewer_output : tdo,
              instr_trace_bits, trace_clk, 1'b0, swdio_out};
        ev = (mr[2] & ev) | (~mr[2] & mr[0]);
        for (int i = 0; i < 10; i++) begin
            d = i == 0 ? swdio_oe & ~jtag_sel :
                i == 7 ? mr[7][1] | tdo_oe : i >= 2 && i <= 6;
            eo[i] = mr[2][i] ? d & mr[1][i] : mr[1][i];
            if (stop_mode && !mr[7][0] && !(mr[2][i] && (i == 0 || i == 7)))
                eo[i] = 1'b0;
        end
        lv = (eo & ev) | (~eo & {trst_n, tdi, 7'h00, tms});
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, run} = '0;
        {stop_mode, jtag_sel, swdio_out, swdio_oe, tdo, tdo_oe} = '0;
        {serial_wire_viewer_output, trace_clk, instr_trace_bits} = '0;
        {tms, tdi, trst_n} = '0;
        {n_rise, n_errors, checks_done} = '0;
        mr = '{0, 10'h081, 10'h383, 10'h303, 10'h301, 10'h002, 0, 0};
        void'($urandom(32'hb229));
        repeat (4) @(posedge pclk);
        chk("pin_pu", pin_pu, 10'h301);
        chk("pin_pd", pin_pd, 10'h002);
        presetn <= 1'b1;
        for (a = 0; a < 8; a++) begin
            apb(0, a * 4, 0);
            if (a != 6) chk("reset reg", rd, mr[a]);
        end
        apb(1, 32, '1);
        apb(0, 32, 0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 0);
        $display("reset and map test done");
        run <= 1'b1;
        repeat (80) @(posedge pclk);
        run <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("tck frame", rises > 0, 1);
        chk("tck rises", n_rise, rises);
        apb(1, 8, mr[2] & ~2);
        base = n_rise;
        run <= 1'b1;
        repeat (40) @(posedge pclk);
        run <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("tck released", n_rise, base);
        $display("clock pin test done");
        for (int n = 0; n < 60; n++) begin
            @(posedge pclk);
            {stop_mode, jtag_sel, swdio_out, swdio_oe, tdo, tdo_oe,
             serial_wire_viewer_output, trace_clk, instr_trace_bits,
             tms, tdi, trst_n} <= 15'($urandom);
            a = $urandom_range(7);
            if (a == 6) a = 2;
            apb(1, a * 4, $urandom);
            repeat (5) @(posedge pclk);
            model();
            chk("pin_oe", pin_oe, eo);
            chk("pin_out", pin_out & ~(mr[2] & 10'h302),
                ev & ~(mr[2] & 10'h302));
            chk("pin_pu", pin_pu, mr[4]);
            chk("pin_pd", pin_pd, mr[5]);
            chk("swdio_in", dbg_swdio_in,
                mr[2][0] & mr[3][0] & lv[0]);
            chk("tck_in", dbg_tck_in, mr[2][1] & mr[3][1] & lv[1]);
            chk("tdi_in", dbg_tdi_in, mr[2][8] & mr[3][8] & lv[8]);
            chk("trst_in", dbg_trst_n_in,
                mr[2][9] & mr[3][9] ? lv[9] : 1'b1);
            apb(0, a * 4, 0);
            chk("readback", rd, mr[a]);
            apb(0, 24, 0);
            chk("pin levels", rd & mr[3] & (eo | 10'h303),
                lv & mr[3] & (eo | 10'h303));
        end
        $display("random pin test done");
        final_report();
    end
endmodule // test_debug_port_pin_sharing
